// ===== hdl/lift_call_and_door_policy.sv
// Call cancellation, door sequencing, interlock and fault policy of a lift car
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Operation
// - Delete car calls after n idle travels
// - Hinged mode counts travels without door opening
// - Call count threshold enters pseudo full load
// - Single-sided access reserves car for calling side
// - Barrier polarity selects interrupted contact level
// - Force limiter polarity selects active contact level
// - Standard selector; extended checks contactor pull-in
// - TRA resumes when upper limit closes
// - EN81 lowers to bottom, then out of order
// - TRA retries after 10 s, second timeout stops
// - EN81 first timeout stops until mode change
// - Mode input: landing off or contactor monitor
// - Group landing call reopens closing door if set
// - Double door opens side 1, then side 2
// - Side 2 first when only side-2 calls
// - Magnets off when stopped between landings
// - Interlock selector never, inoperative, between only
// - Hinged unlock on opening or fully open
module lift_call_and_door_policy
  import lift_policy_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES   = RETRY_CYC,
  parameter int unsigned CONTACT_CYCLES = CONTACT_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // Avalon-MM slave
  input  wire logic [3:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  output logic             irq_o,
  // Car calls and user activity
  input  wire logic        travel_done_i,
  input  wire logic        by_car_call_i,
  input  wire logic        barrier_contact_i,
  input  wire logic        force_contact_i,
  input  wire logic        hinged_open_i,
  input  wire logic [7:0]  car_calls_i,
  output logic             delete_calls_o,
  output logic             full_load_o,
  output logic             barrier_int_o,
  output logic             force_act_o,
  // Single-sided access
  input  wire logic        idle_closed_i,
  input  wire logic        landing_call_i,
  input  wire logic        landing_side2_i,
  input  wire logic [1:0]  side_pending_i,
  output logic [1:0]       reserve_o,
  // Faults and standard
  input  wire logic        limit_hit_i,
  input  wire logic        limit_closed_i,
  input  wire logic        at_bottom_i,
  input  wire logic        time_exceeded_i,
  input  wire logic        travel_start_i,
  input  wire logic        mode_change_i,
  input  wire logic        mode_dependent_input_i,
  output logic             lower_car_o,
  output logic             retry_travel_o,
  output logic             out_of_service_o,
  output logic [3:0]       mode_code_o,
  output logic             landing_ctrl_off_o,
  // Doors and interlocks
  input  wire logic        group_i,
  input  wire logic        door_closing_i,
  input  wire logic        same_dir_call_i,
  input  wire logic        arrival_i,
  input  wire logic [1:0]  car_call_side_i,
  input  wire logic [1:0]  land_call_side_i,
  input  wire logic [1:0]  door_closed_i,
  input  wire logic        stopped_between_i,
  input  wire logic        inoperative_i,
  input  wire logic        car_door_opening_i,
  input  wire logic        car_door_open_i,
  output logic             reopen_door_o,
  output logic             call_to_group_o,
  output logic [1:0]       door_open_o,
  output logic             magnet_off_o,
  output logic             hinged_unlock_o
);
  state_t           s;
  state_t           n;
  logic             lb_now;
  logic             fl_now;
  logic             act_now;
  logic             tra;
  logic [1:0]       side_now;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;
  logic             do_wr;
  logic             inop;

  default clocking dclk @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  assign lb_now   = s.cfg.barrier_pol ? ~barrier_contact_i : barrier_contact_i;
  assign fl_now   = s.cfg.force_pol ? ~force_contact_i : force_contact_i;
  assign act_now  = s.cfg.hinged_mode ? hinged_open_i : lb_now;
  assign tra      = (s.cfg.standard == STD_TRA);
  assign side_now = landing_side2_i ? 2'b10 : 2'b01;
  assign do_wr    = write_i & s.ack;
  assign w1c      = (do_wr && address_i == REG_IRQ_ST) ? writedata_i[IRQ_W-1:0] : '0;
  assign inop     = inoperative_i | (s.fst == F_OUT);

  always_comb begin
    n = s;
    ev = '0;
    // Bus answers one cycle after the request appears
    n.ack = (read_i | write_i) & ~s.ack;
    case (address_i)
      REG_CFG:      n.rdata = {{(32-CFG_W){1'b0}}, s.cfg};
      REG_STATUS:   n.rdata = {8'h00, s.fst, s.reserve, s.full, 3'h0, s.mode, s.count};
      REG_IRQ_ST:   n.rdata = {{(32-IRQ_W){1'b0}}, s.irq_st};
      default:      n.rdata = {{(32-IRQ_W){1'b0}}, s.irq_mask};
    endcase
    if (do_wr && address_i == REG_CFG) begin
      n.cfg = writedata_i[CFG_W-1:0];
    end
    if (do_wr && address_i == REG_IRQ_MASK) begin
      n.irq_mask = writedata_i[IRQ_W-1:0];
    end
    // Contact polarity
    n.lb = lb_now;
    n.fl = fl_now;
    // Idle travel counter; activity in the finishing cycle still counts
    n.del = 1'b0;
    if (act_now) begin
      n.activity = 1'b1;
      n.count = 8'h00;
    end
    if (travel_done_i && by_car_call_i && s.cfg.call_limit != 8'h00) begin
      n.activity = 1'b0;
      if (s.activity || act_now) begin
        n.count = 8'h00;
      end else if (s.count + 8'h01 >= s.cfg.call_limit) begin
        n.del = 1'b1;
        n.count = 8'h00;
      end else begin
        n.count = s.count + 8'h01;
      end
    end else if (travel_done_i) begin
      n.activity = 1'b0;
    end
    // Pseudo full load
    n.full = (s.cfg.full_thr != 8'h00) && (car_calls_i >= s.cfg.full_thr);
    // Single-sided reservation
    if (!s.cfg.single_side) begin
      n.reserve = 2'b00;
    end else if (s.reserve == 2'b00) begin
      if (idle_closed_i && landing_call_i) begin
        n.reserve = side_now;
      end
    end else if ((side_pending_i & s.reserve) == 2'b00 && door_closed_i == 2'b11) begin
      n.reserve = 2'b00;
    end
    // Mode-dependent input
    n.lc_off = tra & mode_dependent_input_i;
    // Fault handling
    n.retry = 1'b0;
    case (s.fst)
      F_RUN: begin
        if (travel_start_i && s.cfg.standard == STD_EXT) begin
          n.chk = 1'b1;
          n.tmr = '0;
        end else if (s.chk) begin
          n.tmr = s.tmr + 1'b1;
          if (mode_dependent_input_i) begin
            n.chk = 1'b0;
          end
        end
        if (limit_hit_i) begin
          n.fst = F_LIMIT;
          n.chk = 1'b0;
        end else if (time_exceeded_i) begin
          n.chk = 1'b0;
          n.tmr = '0;
          n.fst = tra ? F_RWAIT : F_OUT;
          n.mode = tra ? MODE_NORMAL : MODE_OOO;
        end else if (s.chk && !mode_dependent_input_i &&
                     s.tmr >= TMR_W'(CONTACT_CYCLES - 1)) begin
          n.chk = 1'b0;
          n.fst = F_OUT;
          n.mode = MODE_OOO;
        end
      end
      F_RWAIT: begin
        n.tmr = s.tmr + 1'b1;
        if (s.tmr >= TMR_W'(RETRY_CYCLES - 1)) begin
          n.retry = 1'b1;
          n.fst = F_RETRY;
        end
      end
      F_RETRY: begin
        if (time_exceeded_i) begin
          n.fst = F_OUT;
          n.mode = MODE_TIMEOUT;
        end else if (travel_done_i) begin
          n.fst = F_RUN;
        end
      end
      F_LIMIT: begin
        if (limit_closed_i) begin
          n.fst = tra ? F_RUN : F_LOWER;
        end
      end
      F_LOWER: begin
        if (at_bottom_i) begin
          n.fst = F_OUT;
          n.mode = MODE_OOO;
        end
      end
      F_OUT: begin
        if (mode_change_i) begin
          n.fst = F_RUN;
          n.mode = MODE_NORMAL;
        end
      end
      default: begin
        n.fst = F_RUN;
      end
    endcase
    if (n.fst == F_OUT && s.fst != F_OUT) begin
      ev[IRQ_OUT] = 1'b1;
    end
    // Group reopen
    n.reopen   = group_i & door_closing_i & same_dir_call_i & s.cfg.reopen;
    n.to_group = group_i & door_closing_i & same_dir_call_i & ~s.cfg.reopen;
    // Double door sequencing
    case (s.dst)
      D_IDLE: begin
        if (arrival_i && s.cfg.double_door) begin
          n.dst = D_FIRST;
          n.seen_open = 1'b0;
          n.first2 = (car_call_side_i == 2'b10) ||
                     (car_call_side_i == 2'b00 && land_call_side_i == 2'b10);
        end
      end
      D_FIRST: begin
        if (!door_closed_i[s.first2]) begin
          n.seen_open = 1'b1;
        end else if (s.seen_open) begin
          n.dst = D_SECOND;
          n.seen_open = 1'b0;
        end
      end
      D_SECOND: begin
        if (!door_closed_i[~s.first2]) begin
          n.seen_open = 1'b1;
        end else if (s.seen_open) begin
          n.dst = D_IDLE;
          n.seen_open = 1'b0;
        end
      end
      default: begin
        n.dst = D_IDLE;
      end
    endcase
    // Interlock magnets and hinged door unlock
    n.magnet_off = (s.cfg.between_off & stopped_between_i) |
                   (s.cfg.lock_sel == LOCK_ALWAYS && inop) |
                   (s.cfg.lock_sel == LOCK_BETWEEN && stopped_between_i);
    n.unlock = s.cfg.unlock_full ? car_door_open_i : (car_door_opening_i | car_door_open_i);
    // Events; a new event beats a clear in the same cycle
    ev[IRQ_DELETE] = n.del;
    ev[IRQ_FULL]   = n.full & ~s.full;
    ev[IRQ_RETRY]  = n.retry;
    n.irq_st = (s.irq_st & ~w1c) | ev;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '{cfg: CFG_RST, fst: F_RUN, dst: D_IDLE, mode: MODE_NORMAL, default: '0};
    end else begin
      s <= n;
    end
  end

  assign readdata_o         = s.rdata;
  assign waitrequest_o      = (read_i | write_i) & ~s.ack;
  assign irq_o              = |(s.irq_st & s.irq_mask);
  assign delete_calls_o     = s.del;
  assign full_load_o        = s.full;
  assign barrier_int_o      = s.lb;
  assign force_act_o        = s.fl;
  assign reserve_o          = s.reserve;
  assign lower_car_o        = (s.fst == F_LOWER);
  assign retry_travel_o     = s.retry;
  assign out_of_service_o   = (s.fst == F_OUT);
  assign mode_code_o        = s.mode;
  assign landing_ctrl_off_o = s.lc_off;
  assign reopen_door_o      = s.reopen;
  assign call_to_group_o    = s.to_group;
  // Without double-door sequencing no side opens: door_open_o stays 2'b00 on arrival
  assign door_open_o        = (s.dst == D_FIRST)  ? (s.first2 ? 2'b10 : 2'b01) :
                              (s.dst == D_SECOND) ? (s.first2 ? 2'b01 : 2'b10) : 2'b00;
  assign magnet_off_o       = s.magnet_off;
  assign hinged_unlock_o    = s.unlock;

  // Checks
  a_barrier_pol: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ##1 barrier_int_o == ($past(s.cfg.barrier_pol) ^ $past(barrier_contact_i)))
    else $error("barrier polarity wrong");
  a_force_pol: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ##1 force_act_o == ($past(s.cfg.force_pol) ^ $past(force_contact_i)))
    else $error("force limiter polarity wrong");
  a_delete_calls: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    delete_calls_o |-> s.count == 8'h00 && $past(travel_done_i) && $past(by_car_call_i))
    else $error("car calls deleted without idle travel");
  a_full_load: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s.cfg.full_thr == 8'h00) |=> !full_load_o)
    else $error("full load while disabled");
  a_tra_limit: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s.fst == F_LIMIT && limit_closed_i && tra) |=> s.fst == F_RUN)
    else $error("TRA did not resume after limit");
  a_en81_timeout: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s.fst == F_RUN && time_exceeded_i && !limit_hit_i && s.cfg.standard == STD_EN81)
    |=> out_of_service_o && mode_code_o == MODE_OOO)
    else $error("EN81 timeout did not stop");
  a_tra_second: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s.fst == F_RETRY && time_exceeded_i) |=> out_of_service_o && mode_code_o == MODE_TIMEOUT)
    else $error("second timeout not code 2");
  a_retry_wait: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    retry_travel_o |-> $past(s.fst) == F_RWAIT && $past(s.tmr) == TMR_W'(RETRY_CYCLES - 1))
    else $error("retry not after wait");
  a_landing_off: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ##1 landing_ctrl_off_o == ($past(tra) && $past(mode_dependent_input_i)))
    else $error("mode input misread");
  a_magnet_never: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s.cfg.lock_sel == LOCK_NEVER && !s.cfg.between_off) |=> !magnet_off_o)
    else $error("magnets switched off while disabled");
  a_unlock_full: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (s.cfg.unlock_full && !car_door_open_i) |=> !hinged_unlock_o)
    else $error("hinged door unlocked early");
  a_reopen_door: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    reopen_door_o |-> $past(s.cfg.reopen) && $past(door_closing_i) && !call_to_group_o)
    else $error("reopen without cause");
  a_hinged_use: assert property (
    (s.cfg.hinged_mode && hinged_open_i) |=> !delete_calls_o)
    else $error("calls deleted after door use");
  a_full_enter: assert property (
    (s.cfg.full_thr != 8'h00 && car_calls_i >= s.cfg.full_thr) |=> full_load_o)
    else $error("full load not entered");
  a_reserve_hold: assert property (
    (s.cfg.single_side && (side_pending_i & reserve_o) != 2'b00) |=> $stable(reserve_o))
    else $error("reservation dropped early");
  a_lower_bottom: assert property (
    (lower_car_o && at_bottom_i) |=> out_of_service_o && mode_code_o == MODE_OOO)
    else $error("no stop at lowest landing");
  a_tra_wait: assert property (
    (s.fst == F_RUN && time_exceeded_i && !limit_hit_i && tra) |=> !out_of_service_o)
    else $error("TRA timeout did not wait");
  a_out_hold: assert property (
    (out_of_service_o && !mode_change_i) |=> out_of_service_o)
    else $error("left out of service alone");
  a_side1_first: assert property (
    (arrival_i && s.dst == D_IDLE && s.cfg.double_door &&
     !car_call_side_i[1] && !land_call_side_i[1]) |=> door_open_o == 2'b01)
    else $error("side 1 not opened first");
  a_side2_first: assert property (
    (arrival_i && s.dst == D_IDLE && s.cfg.double_door && car_call_side_i == 2'b10)
    |=> door_open_o == 2'b10)
    else $error("side 2 not opened first");
  a_magnet_between: assert property (
    (s.cfg.between_off && stopped_between_i) |=> magnet_off_o)
    else $error("magnets left on between landings");
  c_delete: cover property (@(posedge core_clk_i) disable iff (!nrst_i) delete_calls_o);
  c_retry: cover property (@(posedge core_clk_i) disable iff (!nrst_i) retry_travel_o);
  c_second: cover property (@(posedge core_clk_i) disable iff (!nrst_i) s.dst == D_SECOND);
  c_reserve: cover property (@(posedge core_clk_i) disable iff (!nrst_i) reserve_o == 2'b10);
  c_timeout: cover property (mode_code_o == MODE_TIMEOUT);
endmodule : lift_call_and_door_policy

// ===== shared/lift_policy_pkg.sv
// Constants, register map and carrier types of the lift call and door policy block
package lift_policy_pkg;
  // Register byte offsets
  localparam logic [3:0] REG_CFG      = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_IRQ_ST   = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'hC;
  localparam int         CFG_W        = 28;
  localparam logic [CFG_W-1:0] CFG_RST = 28'h0000000;
  // Interrupt status bit positions
  localparam int IRQ_W       = 4;
  localparam int IRQ_DELETE  = 0;
  localparam int IRQ_FULL    = 1;
  localparam int IRQ_OUT     = 2;
  localparam int IRQ_RETRY   = 3;
  // Standard selector values
  localparam logic [1:0] STD_EN81 = 2'h0;
  localparam logic [1:0] STD_TRA  = 2'h1;
  localparam logic [1:0] STD_EXT  = 2'h2;
  // Interlock switch-off selector values
  localparam logic [1:0] LOCK_NEVER   = 2'h0;
  localparam logic [1:0] LOCK_ALWAYS  = 2'h1;
  localparam logic [1:0] LOCK_BETWEEN = 2'h2;
  // Mode indicator codes
  localparam logic [3:0] MODE_NORMAL  = 4'h0;
  localparam logic [3:0] MODE_TIMEOUT = 4'h2;
  localparam logic [3:0] MODE_OOO     = 4'hF;
  // Timing
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned RETRY_S      = 10;
  localparam int unsigned RETRY_CYC    = RETRY_S * CLK_HZ;
  localparam int unsigned CONTACT_MS   = 200;
  localparam int unsigned CONTACT_CYC  = CONTACT_MS * (CLK_HZ / 1000);
  localparam int          TMR_W        = 28;

  typedef struct packed {
    logic       hinged_mode;
    logic       unlock_full;
    logic [1:0] lock_sel;
    logic       between_off;
    logic       double_door;
    logic       reopen;
    logic [1:0] standard;
    logic       force_pol;
    logic       barrier_pol;
    logic       single_side;
    logic [7:0] full_thr;
    logic [7:0] call_limit;
  } cfg_t;

  typedef enum logic [5:0] {
    F_RUN   = 6'b000001,
    F_RWAIT = 6'b000010,
    F_RETRY = 6'b000100,
    F_LIMIT = 6'b001000,
    F_LOWER = 6'b010000,
    F_OUT   = 6'b100000
  } fault_st_t;

  typedef enum logic [2:0] {
    D_IDLE   = 3'b001,
    D_FIRST  = 3'b010,
    D_SECOND = 3'b100
  } door_st_t;

  typedef struct packed {
    cfg_t             cfg;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic             ack;
    logic [31:0]      rdata;
    logic [7:0]       count;
    logic             activity;
    logic             del;
    logic             full;
    logic [1:0]       reserve;
    fault_st_t        fst;
    logic [TMR_W-1:0] tmr;
    logic             chk;
    logic             retry;
    logic [3:0]       mode;
    door_st_t         dst;
    logic             first2;
    logic             seen_open;
    logic             reopen;
    logic             to_group;
    logic             lb;
    logic             fl;
    logic             magnet_off;
    logic             unlock;
    logic             lc_off;
  } state_t;
endpackage : lift_policy_pkg

// ===== dv/door_partner.sv
// Door drive model: opens a commanded side after a delay, holds it, then closes it
`timescale 1ns/1ps
module door_partner #(
  parameter int HOLD = 3
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  // Command side
  input  wire logic [3:0] dly_i,
  input  wire logic [1:0] cmd_i,
  // Door state
  output logic      [1:0] closed_o
);
  int         cnt [2];
  logic [1:0] done_ff;
  // A dropped command closes the door at once, as a real drive would
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    for (int s = 0; s < 2; s++) begin
      if (!nrst_i || !cmd_i[s]) begin
        cnt[s]      <= 0;
        done_ff[s]  <= 1'b0;
        closed_o[s] <= 1'b1;
      end else if (!done_ff[s]) begin
        cnt[s] <= cnt[s] + 1;
        if (cnt[s] == int'(dly_i)) closed_o[s] <= 1'b0;
        if (cnt[s] == int'(dly_i) + HOLD) begin
          closed_o[s] <= 1'b1;
          done_ff[s]  <= 1'b1;
        end
      end
    end
  end
endmodule : door_partner

// ===== dv/tb_lift_call_and_door_policy.sv
// Self-checking bench of the lift call and door policy block
`timescale 1ns/1ps
module tb_lift_call_and_door_policy
  import lift_policy_pkg::*;
;
  localparam int RC = 20;
  localparam int CC = 8;
  localparam int P_DONE = 0, P_LAND = 1, P_LIMIT = 2, P_TIME = 3, P_START = 4, P_MODE = 5;
  typedef struct packed {logic [31:0] cfg; logic [6:0] in; logic [4:0] exp;} row_t;
  localparam row_t ROWS [13] = '{
    {32'h08000000, 7'b1100000, 5'b11000}, {32'h08060000, 7'b1100000, 5'b00000},
    {32'h08060000, 7'b0000000, 5'b11000}, {32'h08000000, 7'b0000100, 5'b00010},
    {32'h0C000000, 7'b0000100, 5'b00000}, {32'h0C000000, 7'b0000010, 5'b00010},
    {32'h08800000, 7'b0010000, 5'b00100}, {32'h08000000, 7'b0011000, 5'b00000},
    {32'h09000000, 7'b0001000, 5'b00100}, {32'h0A000000, 7'b0001000, 5'b00000},
    {32'h0A000000, 7'b0010000, 5'b00100}, {32'h08080000, 7'b0000001, 5'b00001},
    {32'h08000000, 7'b0000001, 5'b00000}};
  localparam logic [5:0] DD [3] = '{6'b000001, 6'b100010, 6'b001010};
  logic        core_clk_i = 1'b0, nrst_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
  logic [3:0]  address_i = 4'h0, dly_i = 4'h0, mode_code_o;
  logic [31:0] writedata_i = 32'h0, readdata_o;
  logic [7:0]  car_calls_i = 8'h00;
  logic [6:0]  pls = 7'h00, row_in = 7'h00;
  logic [1:0]  side_pending_i = 2'h0, car_call_side_i = 2'h0, land_call_side_i = 2'h0;
  logic [1:0]  door_closed_i, reserve_o, door_open_o;
  logic        by_car_call_i = 1'b1, hinged_open_i = 1'b0, idle_closed_i = 1'b0;
  logic        landing_side2_i = 1'b0, limit_closed_i = 1'b0, at_bottom_i = 1'b0;
  logic        group_i = 1'b0, door_closing_i = 1'b0, same_dir_call_i = 1'b0;
  logic        travel_done_i, landing_call_i, limit_hit_i, time_exceeded_i, travel_start_i;
  logic        mode_change_i, arrival_i, barrier_contact_i, force_contact_i, stopped_between_i;
  logic        inoperative_i, car_door_opening_i, car_door_open_i, mode_dependent_input_i;
  logic        waitrequest_o, irq_o, delete_calls_o, full_load_o, barrier_int_o, force_act_o;
  logic        lower_car_o, retry_travel_o, out_of_service_o, landing_ctrl_off_o;
  logic        reopen_door_o, call_to_group_o, magnet_off_o, hinged_unlock_o;
  logic [4:0]  row_out;
  int          fail_count = 0, n_tests = 0, cyc = 0, k;
  assign {arrival_i, mode_change_i, travel_start_i, time_exceeded_i, limit_hit_i,
          landing_call_i, travel_done_i} = pls;
  assign {barrier_contact_i, force_contact_i, stopped_between_i, inoperative_i,
          car_door_opening_i, car_door_open_i, mode_dependent_input_i} = row_in;
  assign row_out = {barrier_int_o, force_act_o, magnet_off_o, hinged_unlock_o, landing_ctrl_off_o};

  lift_call_and_door_policy #(.RETRY_CYCLES(RC), .CONTACT_CYCLES(CC)) lift_call_and_door_policy_i (.*);
  door_partner door_partner_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .dly_i(dly_i),
                               .cmd_i(door_open_o), .closed_o(door_closed_i));

  always #20 core_clk_i = ~core_clk_i;

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // Long enough for every scenario, short enough to cut a stuck handshake
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Request held until waitrequest is seen low, released after that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk_i);
    address_i   <= a;
    writedata_i <= d;
    write_i     <= wr;
    read_i      <= !wr;
    do @(posedge core_clk_i); while (waitrequest_o !== 1'b0);
    q = readdata_o;
    write_i <= 1'b0;
    read_i  <= 1'b0;
    @(negedge core_clk_i);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  task automatic pulse(input int b);
    @(posedge core_clk_i) pls[b] <= 1'b1;
    @(posedge core_clk_i) pls[b] <= 1'b0;
  endtask : pulse

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : wt

  task automatic trv(input logic exp);
    pulse(P_DONE);
    @(negedge core_clk_i);
    chk(delete_calls_o, exp);
  endtask : trv

  task automatic recover();
    pulse(P_MODE);
    wt(2);
    chk(out_of_service_o, 1'b0);
  endtask : recover

  task automatic wait_ne(input logic [1:0] v);
    k = 0;
    while (door_open_o === v && k < 80) begin
      @(negedge core_clk_i);
      k++;
    end
  endtask : wait_ne

  initial begin
    @(negedge core_clk_i);
    chk({delete_calls_o, out_of_service_o, door_open_o, reserve_o, irq_o, mode_code_o}, 0);
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(REG_CFG, 32'h0);
    rd(REG_IRQ_MASK, 32'h0);
    wr(REG_STATUS, 32'hFFFFFFFF);
    rd(REG_STATUS, 32'h00040000);
    wr(REG_CFG, 32'hFC123456);
    rd(REG_CFG, 32'h0C123456);
    $display("done: reset and registers");
    foreach (ROWS[i]) begin
      wr(REG_CFG, ROWS[i].cfg);
      @(posedge core_clk_i) row_in <= ROWS[i].in;
      wt(2);
      chk(row_out, ROWS[i].exp);
    end
    @(posedge core_clk_i) row_in <= 7'h00;
    $display("done: table");
    wr(REG_CFG, 32'h2);
    trv(1'b0);
    trv(1'b1);
    chk(irq_o, 1'b0);
    rd(REG_IRQ_ST, 32'h1);
    wr(REG_IRQ_MASK, 32'h1);
    chk(irq_o, 1'b1);
    wr(REG_IRQ_ST, 32'h1);
    chk(irq_o, 1'b0);
    trv(1'b0);
    @(posedge core_clk_i) row_in <= 7'h40;
    @(posedge core_clk_i) row_in <= 7'h00;
    trv(1'b0);
    trv(1'b0);
    trv(1'b1);
    wr(REG_CFG, 32'h0);
    trv(1'b0);
    trv(1'b0);
    wr(REG_CFG, 32'h08000001);
    @(posedge core_clk_i) hinged_open_i <= 1'b1;
    @(posedge core_clk_i) hinged_open_i <= 1'b0;
    trv(1'b0);
    trv(1'b1);
    $display("done: call deletion");
    wr(REG_CFG, 32'h00000300);
    @(posedge core_clk_i) car_calls_i <= 8'h02;
    wt(2);
    chk(full_load_o, 1'b0);
    @(posedge core_clk_i) car_calls_i <= 8'h03;
    wt(2);
    chk(full_load_o, 1'b1);
    wr(REG_CFG, 32'h0);
    wt(2);
    chk(full_load_o, 1'b0);
    wr(REG_CFG, 32'h00010000);
    @(posedge core_clk_i) {idle_closed_i, landing_side2_i, side_pending_i} <= 4'b1110;
    pulse(P_LAND);
    wt(1);
    chk(reserve_o, 2'b10);
    @(posedge core_clk_i) {idle_closed_i, landing_side2_i, side_pending_i} <= 4'b0010;
    pulse(P_LAND);
    wt(2);
    chk(reserve_o, 2'b10);
    @(posedge core_clk_i) side_pending_i <= 2'b00;
    wt(2);
    chk(reserve_o, 2'b00);
    $display("done: full load and reservation");
    wr(REG_CFG, 32'h00080000);
    pulse(P_LIMIT);
    rd(REG_STATUS, 32'h00200000);
    @(posedge core_clk_i) limit_closed_i <= 1'b1;
    wt(2);
    rd(REG_STATUS, 32'h00040000);
    @(posedge core_clk_i) limit_closed_i <= 1'b0;
    wr(REG_CFG, 32'h0);
    pulse(P_LIMIT);
    @(posedge core_clk_i) limit_closed_i <= 1'b1;
    wt(2);
    chk(lower_car_o, 1'b1);
    @(posedge core_clk_i) at_bottom_i <= 1'b1;
    wt(2);
    chk({out_of_service_o, mode_code_o}, {1'b1, MODE_OOO});
    recover();
    wr(REG_CFG, 32'h00080000);
    pulse(P_TIME);
    k = 0;
    while (retry_travel_o !== 1'b1 && k < 4 * RC) begin
      @(negedge core_clk_i);
      k++;
    end
    chk(k inside {[RC-1:RC+2]}, 1'b1);
    pulse(P_TIME);
    wt(1);
    chk({out_of_service_o, mode_code_o}, {1'b1, MODE_TIMEOUT});
    recover();
    wr(REG_CFG, 32'h0);
    pulse(P_TIME);
    wt(1);
    chk({out_of_service_o, mode_code_o}, {1'b1, MODE_OOO});
    recover();
    wr(REG_CFG, 32'h00100000);
    @(posedge core_clk_i) row_in <= 7'h01;
    pulse(P_START);
    wt(CC + 4);
    chk(out_of_service_o, 1'b0);
    @(posedge core_clk_i) row_in <= 7'h00;
    pulse(P_START);
    wt(CC + 4);
    chk({out_of_service_o, mode_code_o}, {1'b1, MODE_OOO});
    recover();
    $display("done: standards and faults");
    @(posedge core_clk_i) {group_i, door_closing_i, same_dir_call_i} <= 3'b111;
    for (int r = 0; r < 2; r++) begin
      wr(REG_CFG, 32'(r) << 21);
      wt(2);
      chk({reopen_door_o, call_to_group_o}, (r == 1) ? 2'b10 : 2'b01);
    end
    @(posedge core_clk_i) {group_i, door_closing_i, same_dir_call_i} <= 3'b000;
    wr(REG_CFG, 32'h00400000);
    // Door drive delay steps up 0, 5, 10 cycles across the cases
    foreach (DD[i]) begin
      @(posedge core_clk_i) {car_call_side_i, land_call_side_i, dly_i} <= {DD[i][5:2], 4'(i * 5)};
      pulse(6);
      wt(1);
      chk(door_open_o, DD[i][1:0]);
      wait_ne(DD[i][1:0]);
      chk({door_open_o, door_closed_i}, {~DD[i][1:0], 2'b11});
      wait_ne(~DD[i][1:0]);
      chk(door_open_o, 2'b00);
    end
    $display("done: doors");
    print_verdict();
  end
endmodule : tb_lift_call_and_door_policy
